// ===== smcs_map.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * stop-mode clock sequencer.
 * Assumes a 100 MHz core clock and an oscillator tick input that
 * pulses once for each oscillator cycle.
 */
`ifndef SMCS_MAP_SVH
`define SMCS_MAP_SVH

// Register byte addresses
`define SMCS_ADDR_CTRL    8'h00
`define SMCS_ADDR_STAT    8'h04

// Control field positions and reset value
`define SMCS_CTRL_PLL_CLOCK_SELECT  0
`define SMCS_CTRL_PSTOP   1
`define SMCS_CTRL_WDT     2
`define SMCS_CTRL_TICK    3
`define SMCS_CTRL_CME     4
`define SMCS_CTRL_SELF_CLOCK_MODE_ENABLE    5
`define SMCS_CTRL_SELFCLOCK_IRQ_ENABLE   6
`define SMCS_CTRL_RST     7'h30

// Status field positions
`define SMCS_STAT_FLAG    0
`define SMCS_STAT_SCM     1
`define SMCS_STAT_STOP    2
`define SMCS_STAT_QC      3

// Clock enables out of reset: all on, regulator at full power
`define SMCS_CLK_RST      7'h7e

// Quality check: oscillator cycles for a pass
`define SMCS_QC_OSC_CYC   13'h1000
// Check windows after full stop, and core cycles per window
`define SMCS_CHK_WIN_MAX  6'h32
`define SMCS_CHK_WIN_CYC  8'h20

`endif

// ===== smcs_pkg.sv
/*
 * Types of the stop-mode clock sequencer.
 * Assumes smcs_map.svh holds all numeric constants.
 */
package smcs_pkg;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_CLR_SEL,
        ST_PLL_OFF,
        ST_CORE_OFF,
        ST_SYS_OFF,
        ST_STOP,
        ST_CHK
    } smcs_state_e;

    typedef struct packed {
        logic selfclock_irq_enable;
        logic self_clock_mode_enable;
        logic clock_monitor_enable;
        logic tick_en;
        logic wdt_en;
        logic pstop;
        logic pll_sel;
    } smcs_cfg_s;

    typedef struct packed {
        logic osc_en;
        logic pll_en;
        logic core_en;
        logic sys_en;
        logic wdt_en;
        logic tick_en;
        logic voltage_regulator_low;
    } smcs_clk_s;

endpackage

// ===== smcs_top.sv
/*
 * Stop-mode clock sequencer: shuts clocks down in order on a stop
 * request, handles pseudo-stop and full stop, clock loss, the
 * quality checker and wake-up.
 * Assumes all inputs are synchronous to core_clk and that osc_tick
 * pulses once per oscillator cycle while the oscillator runs.
 */
// Strobed register access and the register addresses were decided locally.
// Contract
// - In stop, gate clocks per settings; oscillator off unless pseudo-stop.
// - Counters and dividers freeze in stop and are not reinitialised.
// - In pseudo-stop, tick and watchdog keep running when enabled.
// - On stop entry, ask regulator and others for low power.
// - Clear PLL select, then PLL off, core off, system off, stop.
// - Pseudo-stop from self-clock keeps checking, PLL and regulator on.
// - Full stop from self-clock aborts check; full window check on exit.
// - External reset restores config asynchronously and starts reset.
// - Monitor on, self-clock off: loss in pseudo-stop gives monitor reset.
// - Self-clock interrupt on: loss raises flag, enters self-clock, wakes.
// - Self-clock interrupt off: loss sets flag but does not wake.
// - Other wake-up resumes at once on oscillator, PLL select cleared.
// - Monitor off: clock loss in pseudo-stop causes no action.
// - Loss with self-clock on: PLL, regulator on, check, set flag.
// - Recovery passes after 4096 oscillator cycles; PLL, regulator off.
// - After recovery, wake-up or reset exits on oscillator clock.
// - Not recovered at wake: exit in self-clock, keep checking.
// - Full stop wake runs at most fifty check windows first.
// - Clock monitor is disabled during full stop.
`timescale 1ns/1ps
`include "smcs_map.svh"

module smcs_top (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    // Register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata,
    // Core and wake-up sources
    input  wire logic               stop_req,
    input  wire logic               wake_irq,
    input  wire logic               ext_reset_b,
    // Oscillator monitor
    input  wire logic               osc_tick,
    input  wire logic               clock_loss,
    // Clock and power control
    output smcs_pkg::smcs_clk_s     clk_ctl,
    output logic                    pll_clock_select,
    output logic                    self_clock_mode,
    output logic                    selfclock_irq,
    output logic                    stop_active,
    output logic                    clock_monitor_reset,
    output logic                    reset_gen_start
);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    smcs_pkg::smcs_state_e  state_q;
    smcs_pkg::smcs_cfg_s    cfg_q;
    smcs_pkg::smcs_clk_s    clk_d;
    smcs_pkg::smcs_clk_s    clk_q;
    logic                   full_q;
    logic                   rst_pend_q;
    logic                   scm_q;
    logic                   qc_q;
    logic                   flag_q;
    logic                   irq_q;
    logic                   stop_q;
    logic                   cmr_q;
    logic                   rgs_q;
    logic [12:0]            osc_cnt_q;
    logic [5:0]             win_cnt_q;
    logic [7:0]             win_cyc_q;
    logic [7:0]             rdata_q;
    logic                   cfg_rst_b;
    logic                   in_stop;
    logic                   cm_live;
    logic                   loss_evt;
    logic                   qc_pass;
    logic                   win_end;
    logic                   win_last;
    logic                   chk_pass;
    logic                   chk_tmo;
    logic                   wr_ctrl;
    logic                   wr_stat;

    ////////////////////////////////////////////////////////////////////
    // Event decode

    assign in_stop  = (state_q == smcs_pkg::ST_STOP);
    assign cfg_rst_b = rst_b & ext_reset_b;
    assign cm_live  = cfg_q.clock_monitor_enable & ~(in_stop & full_q);
    assign loss_evt = cm_live & clock_loss & ~scm_q;
    assign qc_pass  = qc_q & osc_tick & ~clock_loss &
                      (osc_cnt_q == `SMCS_QC_OSC_CYC - 13'h0001);
    assign win_end  = (state_q == smcs_pkg::ST_CHK) &
                      (win_cyc_q == `SMCS_CHK_WIN_CYC - 8'h01);
    assign win_last = (win_cnt_q == `SMCS_CHK_WIN_MAX - 6'h01);
    assign chk_pass = win_end & ~clock_loss;
    assign chk_tmo  = win_end & clock_loss & win_last;
    assign wr_ctrl  = reg_wr & (reg_addr == `SMCS_ADDR_CTRL);
    assign wr_stat  = reg_wr & (reg_addr == `SMCS_ADDR_STAT);

    ////////////////////////////////////////////////////////////////////
    // Configuration, reset asynchronously by either reset

    always_ff @(posedge core_clk or negedge cfg_rst_b) begin
        if (!cfg_rst_b) begin
            cfg_q <= `SMCS_CTRL_RST;
        end else if (state_q == smcs_pkg::ST_CLR_SEL) begin
            cfg_q.pll_sel <= 1'b0;
        end else if (wr_ctrl) begin
            cfg_q <= reg_wdata[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= smcs_pkg::ST_RUN;
        end else begin
            case (state_q)
                smcs_pkg::ST_RUN: begin
                    if (stop_req) begin
                        state_q <= smcs_pkg::ST_CLR_SEL;
                    end
                end
                smcs_pkg::ST_CLR_SEL:
                    state_q <= smcs_pkg::ST_PLL_OFF;
                smcs_pkg::ST_PLL_OFF:
                    state_q <= smcs_pkg::ST_CORE_OFF;
                smcs_pkg::ST_CORE_OFF:
                    state_q <= smcs_pkg::ST_SYS_OFF;
                smcs_pkg::ST_SYS_OFF:
                    state_q <= smcs_pkg::ST_STOP;
                smcs_pkg::ST_STOP: begin
                    if (full_q) begin
                        if (wake_irq || !ext_reset_b) begin
                            state_q <= smcs_pkg::ST_CHK;
                        end
                    end else if (loss_evt && !cfg_q.self_clock_mode_enable) begin
                        state_q <= smcs_pkg::ST_RUN;
                    end else if (loss_evt && cfg_q.selfclock_irq_enable) begin
                        state_q <= smcs_pkg::ST_RUN;
                    end else if (wake_irq || !ext_reset_b) begin
                        state_q <= smcs_pkg::ST_RUN;
                    end
                end
                smcs_pkg::ST_CHK: begin
                    if (chk_pass || chk_tmo) begin
                        state_q <= smcs_pkg::ST_RUN;
                    end
                end
                default:
                    state_q <= smcs_pkg::ST_RUN;
            endcase
        end
    end

    // Mode is latched at entry; an external reset may clear the select
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            full_q <= 1'b0;
        end else if (state_q == smcs_pkg::ST_CLR_SEL) begin
            full_q <= ~cfg_q.pstop;
        end
    end

    // A reset taken during full stop waits for the window check
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pend_q <= 1'b0;
        end else if (in_stop && full_q && !ext_reset_b) begin
            rst_pend_q <= 1'b1;
        end else if (state_q == smcs_pkg::ST_RUN) begin
            rst_pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Window counters for the full stop exit check

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            win_cyc_q <= 8'h00;
            win_cnt_q <= 6'h00;
        end else if (state_q != smcs_pkg::ST_CHK) begin
            win_cyc_q <= 8'h00;
            win_cnt_q <= 6'h00;
        end else if (win_end) begin
            win_cyc_q <= 8'h00;
            win_cnt_q <= win_last ? win_cnt_q : win_cnt_q + 6'h01;
        end else begin
            win_cyc_q <= win_cyc_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Self-clock mode and quality checker

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            scm_q <= 1'b0;
        end else if ((loss_evt && cfg_q.self_clock_mode_enable) ||
                     (chk_tmo && cfg_q.self_clock_mode_enable)) begin
            scm_q <= 1'b1;
        end else if (qc_pass || chk_pass) begin
            scm_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            qc_q <= 1'b0;
        end else if ((loss_evt && cfg_q.self_clock_mode_enable) ||
                     (chk_tmo && cfg_q.self_clock_mode_enable)) begin
            qc_q <= 1'b1;
        end else if (state_q == smcs_pkg::ST_CLR_SEL && !cfg_q.pstop) begin
            qc_q <= 1'b0;
        end else if (state_q == smcs_pkg::ST_CHK && scm_q) begin
            qc_q <= 1'b0;
        end else if (qc_pass) begin
            qc_q <= 1'b0;
        end
    end

    // Counts oscillator cycles; any loss restarts the count
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_cnt_q <= 13'h0000;
        end else if (!qc_q || clock_loss || qc_pass) begin
            osc_cnt_q <= 13'h0000;
        end else if (osc_tick) begin
            osc_cnt_q <= osc_cnt_q + 13'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Self-clock flag: a loss in the clear cycle still sets it

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
        end else if (loss_evt && cfg_q.self_clock_mode_enable) begin
            flag_q <= 1'b1;
        end else if (wr_stat && reg_wdata[`SMCS_STAT_FLAG]) begin
            flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock gating

    always_comb begin
        clk_d = '0;
        clk_d.sys_en  = (state_q == smcs_pkg::ST_RUN) ||
                        (state_q == smcs_pkg::ST_CLR_SEL) ||
                        (state_q == smcs_pkg::ST_PLL_OFF) ||
                        (state_q == smcs_pkg::ST_CORE_OFF);
        clk_d.core_en = (state_q == smcs_pkg::ST_RUN) ||
                        (state_q == smcs_pkg::ST_CLR_SEL) ||
                        (state_q == smcs_pkg::ST_PLL_OFF);
        clk_d.pll_en  = scm_q || (state_q == smcs_pkg::ST_RUN) ||
                        (state_q == smcs_pkg::ST_CLR_SEL);
        clk_d.osc_en  = !(in_stop && full_q);
        clk_d.wdt_en  = clk_d.sys_en ||
                        (in_stop && !full_q && cfg_q.wdt_en);
        clk_d.tick_en = clk_d.sys_en ||
                        (in_stop && !full_q && cfg_q.tick_en);
        clk_d.voltage_regulator_low = in_stop && !scm_q;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_q <= `SMCS_CLK_RST;
        end else begin
            clk_q <= clk_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status outputs and reset requests

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stop_q <= 1'b0;
        end else begin
            stop_q <= in_stop && !clk_q.sys_en;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmr_q <= 1'b0;
            rgs_q <= 1'b0;
        end else begin
            cmr_q <= (in_stop && !full_q && loss_evt && !cfg_q.self_clock_mode_enable) ||
                     (chk_tmo && !cfg_q.self_clock_mode_enable);
            rgs_q <= (in_stop && !full_q && !ext_reset_b) ||
                     ((chk_pass || chk_tmo) && rst_pend_q) ||
                     (in_stop && !full_q && loss_evt && !cfg_q.self_clock_mode_enable) ||
                     (chk_tmo && !cfg_q.self_clock_mode_enable);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= flag_q && cfg_q.selfclock_irq_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else if (reg_rd && reg_addr == `SMCS_ADDR_CTRL) begin
            rdata_q <= {1'b0, cfg_q};
        end else if (reg_rd && reg_addr == `SMCS_ADDR_STAT) begin
            rdata_q <= {4'h0, qc_q, stop_q, scm_q, flag_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata           = rdata_q;
    assign clk_ctl             = clk_q;
    assign pll_clock_select    = cfg_q.pll_sel;
    assign self_clock_mode     = scm_q;
    assign selfclock_irq       = irq_q;
    assign stop_active         = stop_q;
    assign clock_monitor_reset = cmr_q;
    assign reset_gen_start     = rgs_q;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_stop_order: assert property (
        state_q == smcs_pkg::ST_CLR_SEL |=>
        state_q == smcs_pkg::ST_PLL_OFF ##1
        state_q == smcs_pkg::ST_CORE_OFF ##1
        state_q == smcs_pkg::ST_SYS_OFF ##1
        state_q == smcs_pkg::ST_STOP)
        else $error("stop entry order broken");

    a_sel_cleared: assert property (
        state_q == smcs_pkg::ST_PLL_OFF |-> !cfg_q.pll_sel)
        else $error("PLL select not cleared");

    a_stop_late: assert property (
        $rose(stop_q) |-> !clk_q.sys_en && $past(in_stop))
        else $error("stop active before gates closed");

    a_osc_off: assert property (
        in_stop && full_q && $past(in_stop) |-> !clk_q.osc_en)
        else $error("oscillator running in full stop");

    a_wdt_run: assert property (
        in_stop && !full_q && cfg_q.wdt_en |=> clk_q.wdt_en)
        else $error("watchdog clock stopped in pseudo-stop");

    a_cm_reset: assert property (
        in_stop && !full_q && loss_evt && !cfg_q.self_clock_mode_enable
        |=> cmr_q && rgs_q ##1 !cmr_q)
        else $error("monitor reset not pulsed");

    a_flag_hold: assert property (
        in_stop && !full_q && loss_evt && cfg_q.self_clock_mode_enable &&
        !cfg_q.selfclock_irq_enable && !wake_irq && ext_reset_b
        |=> in_stop && flag_q)
        else $error("woke with interrupt disabled");

    a_full_nocm: assert property (
        in_stop && full_q |=> !cmr_q && !$rose(flag_q) && !$rose(scm_q))
        else $error("clock loss acted on in full stop");

    a_chk_bound: assert property (
        state_q == smcs_pkg::ST_CHK |-> win_cnt_q < `SMCS_CHK_WIN_MAX)
        else $error("too many check windows");

    a_qc_leave: assert property (
        qc_pass |=> !scm_q && !qc_q)
        else $error("self-clock kept after pass");

    c_pseudo_wake: cover property (
        in_stop && !full_q && wake_irq ##1 state_q == smcs_pkg::ST_RUN);
    c_full_wake: cover property (
        state_q == smcs_pkg::ST_CHK ##1 state_q == smcs_pkg::ST_RUN);
    c_loss_stop: cover property (
        in_stop && loss_evt && cfg_q.self_clock_mode_enable);

endmodule

// ===== smcs_core_model.sv
/*
 * Behavioural model of the core and oscillator beside the stop-mode
 * clock sequencer: stop request, wake-up interrupt, oscillator ticks
 * and the clock monitor's loss indication.
 * Assumes the bench commands every request and oscillator failure.
 */
`timescale 1ns/1ps

module smcs_core_model (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    // Bench commands
    input  wire logic               stop_cmd,
    input  wire logic               wake_cmd,
    input  wire logic               osc_dead,
    // Clock enables from the sequencer
    input  wire smcs_pkg::smcs_clk_s clk_ctl,
    // Requests and oscillator status
    output logic                    stop_req,
    output logic                    wake_irq,
    output logic                    osc_tick,
    output logic                    clock_loss
);

    ////////////////////////////////////////////////////////////////////
    // stop after instruction
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stop_req <= 1'b0;
            wake_irq <= 1'b0;
        end else begin
            stop_req <= stop_cmd;
            wake_irq <= wake_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Oscillator runs at half the core rate, and only while enabled
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_tick <= 1'b0;
        end else begin
            osc_tick <= clk_ctl.osc_en & ~osc_dead & ~osc_tick;
        end
    end

    // Monitor reports a dead oscillator at once
    assign clock_loss = osc_dead;

endmodule

// ===== testbench.sv
/*
 * Self-checking bench of the stop-mode clock sequencer: full stop,
 * pseudo-stop, clock loss, recovery and wake-up.
 * Assumes the core model stands on the far side of the sequencer.
 */
`timescale 1ns/1ps

module testbench;

    logic                core_clk;
    logic                rst_b;
    logic                ext_reset_b;
    logic [7:0]          reg_addr;
    logic [7:0]          reg_wdata;
    logic [7:0]          reg_rdata;
    logic                reg_wr, reg_rd, stop_req, wake_irq;
    logic                osc_tick, clock_loss, stop_cmd, wake_cmd;
    logic                osc_dead, pll_clock_select, self_clock_mode;
    logic                selfclock_irq, stop_active;
    logic                clock_monitor_reset, reset_gen_start;
    smcs_pkg::smcs_clk_s clk_ctl;
    logic [7:0]          cmr_n, rgs_n;
    int                  num_errors, check_count, cyc_n;

    smcs_top i_dut (.core_clk(core_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_req(stop_req),
        .wake_irq(wake_irq), .ext_reset_b(ext_reset_b),
        .osc_tick(osc_tick), .clock_loss(clock_loss), .clk_ctl(clk_ctl),
        .pll_clock_select(pll_clock_select),
        .self_clock_mode(self_clock_mode), .selfclock_irq(selfclock_irq),
        .stop_active(stop_active),
        .clock_monitor_reset(clock_monitor_reset),
        .reset_gen_start(reset_gen_start));

    smcs_core_model i_core (.core_clk(core_clk), .rst_b(rst_b),
        .stop_cmd(stop_cmd), .wake_cmd(wake_cmd), .osc_dead(osc_dead),
        .clk_ctl(clk_ctl), .stop_req(stop_req), .wake_irq(wake_irq),
        .osc_tick(osc_tick), .clock_loss(clock_loss));

    ////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Pulses are one cycle long, so they are counted, not sampled
    always @(posedge core_clk) begin
        cyc_n++;
        if (clock_monitor_reset === 1'b1) cmr_n++;
        if (reset_gen_start === 1'b1) rgs_n++;
        if (cyc_n == 30000) begin
            num_errors++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task complete_run;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(n, e, reg_rdata);
    endtask

    task wait_stop(input logic lvl, input int n);
        for (int i = 0; i < n && stop_active !== lvl; i++) cyc(1);
        chk("stop_active", {7'h00, lvl}, {7'h00, stop_active});
    endtask

    task enter_stop(input logic [7:0] cfg);
        wr(8'h00, cfg);
        @(posedge core_clk);
        stop_cmd <= 1'b1;
        @(posedge core_clk);
        stop_cmd <= 1'b0;
        wait_stop(1'b1, 20);
        chk("sys_en", 8'h00, {7'h00, clk_ctl.sys_en});
        chk("pll_sel", 8'h00, {7'h00, pll_clock_select});
        cyc(2);
    endtask

    task wake;
        @(posedge core_clk);
        wake_cmd <= 1'b1;
        @(posedge core_clk);
        wake_cmd <= 1'b0;
    endtask

    task do_reset;
        @(posedge core_clk);
        rst_b <= 1'b0;
        cyc(2);
        rst_b <= 1'b1;
        cmr_n = 8'h00;
        rgs_n = 8'h00;
        cyc(1);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b, reg_wr, reg_rd, stop_cmd, wake_cmd, osc_dead} = 6'h00;
        {reg_addr, reg_wdata} = 16'h0000;
        ext_reset_b = 1'b1;
        {cmr_n, rgs_n} = 16'h0000;
        {num_errors, check_count, cyc_n} = '0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        cyc(1);
        chk("clk_ctl", 8'h7e, {1'b0, clk_ctl});
        rd(8'h00, 8'h30, "ctrl");
        rd(8'h04, 8'h00, "status");
        rd(8'h08, 8'h00, "unmapped");
        // Full stop from the PLL clock, loss ignored, clean wake
        // Monitor enabled so that a live monitor would show up
        enter_stop(8'h11);
        chk("clk_ctl", 8'h01, {1'b0, clk_ctl});
        osc_dead <= 1'b1;
        cyc(20);
        osc_dead <= 1'b0;
        chk("cm_reset", 8'h00, cmr_n);
        chk("held", 8'h01, {7'h00, stop_active});
        wake();
        wait_stop(1'b0, 1700);
        // Clocks stay gated while the window check runs
        chk("clk_ctl", 8'h40, {1'b0, clk_ctl});
        cyc(40);
        chk("clk_ctl", 8'h7e, {1'b0, clk_ctl});
        chk("pll_sel", 8'h00, {7'h00, pll_clock_select});
        wr(8'h00, 8'h01);
        cyc(1);
        chk("pll_sel", 8'h01, {7'h00, pll_clock_select});
        // Pseudo-stop with watchdog and tick, monitor off
        enter_stop(8'h0e);
        chk("clk_ctl", 8'h47, {1'b0, clk_ctl});
        osc_dead <= 1'b1;
        cyc(10);
        chk("held", 8'h01, {7'h00, stop_active});
        osc_dead <= 1'b0;
        wake();
        wait_stop(1'b0, 5);
        // Monitor on, self-clock off
        enter_stop(8'h12);
        chk("clk_ctl", 8'h41, {1'b0, clk_ctl});
        osc_dead <= 1'b1;
        wait_stop(1'b0, 5);
        cyc(2);
        osc_dead <= 1'b0;
        chk("cm_reset", 8'h01, cmr_n);
        chk("rst_start", 8'h01, rgs_n);
        // Loss with interrupt blocked, recovery, later wake
        do_reset();
        enter_stop(8'h32);
        osc_dead <= 1'b1;
        cyc(5);
        rd(8'h04, 8'h0f, "status");
        chk("pll_en", 8'h01, {7'h00, clk_ctl.pll_en});
        osc_dead <= 1'b0;
        cyc(8000);
        chk("scm", 8'h01, {7'h00, self_clock_mode});
        cyc(800);
        chk("scm", 8'h00, {7'h00, self_clock_mode});
        chk("pll_en", 8'h00, {7'h00, clk_ctl.pll_en});
        chk("held", 8'h01, {7'h00, stop_active});
        wake();
        wait_stop(1'b0, 5);
        chk("scm", 8'h00, {7'h00, self_clock_mode});
        // Loss with interrupt enabled, then stop from self-clock
        do_reset();
        enter_stop(8'h72);
        osc_dead <= 1'b1;
        wait_stop(1'b0, 10);
        cyc(2);
        chk("irq", 8'h01, {7'h00, selfclock_irq});
        chk("scm", 8'h01, {7'h00, self_clock_mode});
        osc_dead <= 1'b0;
        wr(8'h04, 8'h01);
        enter_stop(8'h32);
        chk("pll_en", 8'h01, {7'h00, clk_ctl.pll_en});
        chk("scm", 8'h01, {7'h00, self_clock_mode});
        // Wake before the oscillator is good again
        do_reset();
        enter_stop(8'h32);
        osc_dead <= 1'b1;
        cyc(5);
        osc_dead <= 1'b0;
        wake();
        wait_stop(1'b0, 5);
        chk("scm", 8'h01, {7'h00, self_clock_mode});
        // Full stop from self-clock drops the running check
        enter_stop(8'h30);
        rd(8'h04, 8'h07, "status");
        wake();
        cyc(40);
        chk("scm", 8'h00, {7'h00, self_clock_mode});
        // External reset in pseudo-stop
        do_reset();
        enter_stop(8'h0e);
        ext_reset_b <= 1'b0;
        cyc(2);
        ext_reset_b <= 1'b1;
        wait_stop(1'b0, 5);
        cyc(2);
        chk("rst_start", 8'h01, rgs_n);
        rd(8'h00, 8'h30, "ctrl");
        complete_run();
    end

endmodule
